// >>> hw/iso_defs.vh
// Constants for the isolator channel with refresh and watchdog
`ifndef ISO_DEFS_VH
`define ISO_DEFS_VH

`define ISO_CLK_MHZ 50
`define ISO_TICK_US 1
`define ISO_TICK_CYC (`ISO_TICK_US * `ISO_CLK_MHZ)
`define ISO_REFRESH_US 140
`define ISO_REFRESH_TICKS (`ISO_REFRESH_US / `ISO_TICK_US)
`define ISO_WDOG_US 200
`define ISO_WDOG_TICKS (`ISO_WDOG_US / `ISO_TICK_US)
`define ISO_RESTORE_US 150
`define ISO_CNT_W 16

`define ISO_WORD_W 2
`define ISO_WORD_LVL 0
`define ISO_WORD_RFR 1
`define ISO_FIFO_DEPTH 32
`define ISO_FIFO_AW 5

`define ISO_PIN_N 5
`define ISO_PIN_DATA 0
`define ISO_PIN_CTL1 1
`define ISO_PIN_CTL2 2
`define ISO_PIN_PWR1 3
`define ISO_PIN_PWR2 4
`define ISO_PIN_RST 5'h06

`endif

// >>> hw/iso_fifo.v
// Barrier pulse FIFO with registered read stage
`timescale 1ns/1ns
module iso_fifo #(
	parameter W = 2,
	parameter DEPTH = 32,
	parameter AW = 5
) (
	// Clock and reset
	input wire clk_in,
	input wire nrst_in,
	input wire en_in,
	input wire flush_in,
	// Write side
	input wire in_valid_in,
	input wire [W-1:0] in_data_in,
	output wire in_ready_out,
	// Read side
	output wire out_valid_out,
	output wire [W-1:0] out_data_out,
	input wire out_ready_in
);
	localparam integer DEPTH_I = DEPTH;
	localparam [AW:0] FULL = DEPTH_I[AW:0];

	reg [W-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_q;
	reg [AW-1:0] rd_q;
	reg [AW:0] cnt_q;
	reg ov_q;
	reg [W-1:0] od_q;

	wire push = in_valid_in && (cnt_q != FULL) && !flush_in;
	wire take = ov_q && out_ready_in;
	wire load = (cnt_q != {(AW+1){1'b0}}) && (!ov_q || take) && !flush_in;

	// Storage without reset
	always @(posedge clk_in) begin
		if (en_in && push) begin
			mem[wr_q] <= in_data_in;
		end
	end

	always @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			wr_q <= {AW{1'b0}};
			rd_q <= {AW{1'b0}};
			cnt_q <= {(AW+1){1'b0}};
			ov_q <= 1'b0;
			od_q <= {W{1'b0}};
		end else if (en_in) begin
			if (flush_in) begin
				wr_q <= {AW{1'b0}};
				rd_q <= {AW{1'b0}};
				cnt_q <= {(AW+1){1'b0}};
				ov_q <= 1'b0;
			end else begin
				if (push) begin
					wr_q <= wr_q + {{(AW-1){1'b0}}, 1'b1};
				end
				if (load) begin
					od_q <= mem[rd_q];
					rd_q <= rd_q + {{(AW-1){1'b0}}, 1'b1};
				end
				cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};
				ov_q <= load | (ov_q & ~take);
			end
		end
	end

	assign in_ready_out = (cnt_q != FULL);
	assign out_valid_out = ov_q;
	assign out_data_out = od_q;
endmodule

// >>> hw/iso_sync.v
// Two-stage synchroniser for a group of pin inputs
`timescale 1ns/1ns
module iso_sync #(
	parameter W = 5,
	parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
	// Clock and reset
	input wire clk_in,
	input wire nrst_in,
	input wire en_in,
	// Data
	input wire [W-1:0] d_in,
	output wire [W-1:0] q_out
);
	reg [W-1:0] meta_q;
	reg [W-1:0] sync_q;

	always @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			meta_q <= RST_VAL;
			sync_q <= RST_VAL;
		end else if (en_in) begin
			meta_q <= d_in;
			sync_q <= meta_q;
		end
	end

	assign q_out = sync_q;
endmodule

// >>> hw/iso_top.v
// One isolator channel: edge encoder, barrier FIFO, bistable decoder, refresh, watchdog
`timescale 1ns/1ns
`include "iso_defs.vh"
module iso_top #(
	parameter DEFAULT_HIGH = 1,
	parameter TICK_CYC = `ISO_TICK_CYC,
	parameter REFRESH_TICKS = `ISO_REFRESH_TICKS,
	parameter WDOG_TICKS = `ISO_WDOG_TICKS
) (
	// Clock, reset, enable
	input wire ref_clk_in,
	input wire nrst_in,
	input wire clk_en_in,
	// Input side pins
	input wire channel_a_input_in,
	input wire refresh_ctl_side1_n_in,
	input wire side1_power_ok_in,
	// Output side pins
	input wire refresh_ctl_side2_n_in,
	input wire side2_power_ok_in,
	output wire channel_a_output_out,
	output wire channel_a_output_oe_n_out,
	// Status
	output wire watchdog_tripped_out,
	output wire refresh_active_out,
	output wire barrier_full_out
);
	localparam CW = `ISO_CNT_W;
	localparam WW = `ISO_WORD_W;
	localparam integer TICK_LAST_I = TICK_CYC - 1;
	localparam integer RFR_LAST_I = REFRESH_TICKS - 1;
	// Timeout always above the refresh interval
	localparam integer WDOG_LIM_I = (WDOG_TICKS > REFRESH_TICKS) ? WDOG_TICKS
		: REFRESH_TICKS + 1;
	localparam [CW-1:0] TICK_LAST = TICK_LAST_I[CW-1:0];
	localparam [CW-1:0] RFR_LAST = RFR_LAST_I[CW-1:0];
	localparam [CW-1:0] WDOG_LIM = WDOG_LIM_I[CW-1:0];
	localparam [CW-1:0] CNT_ONE = {{(CW-1){1'b0}}, 1'b1};
	localparam [0:0] DEF_LVL = (DEFAULT_HIGH != 0) ? 1'b1 : 1'b0;

	// Counter has reached its limit
	function reached;
		input [CW-1:0] cnt;
		input [CW-1:0] lim;
		begin
			reached = (cnt >= lim);
		end
	endfunction

	// Counter step with saturation
	function [CW-1:0] step;
		input [CW-1:0] cnt;
		begin
			step = (&cnt) ? cnt : cnt + CNT_ONE;
		end
	endfunction

	// Barrier word from refresh flag and level
	function [WW-1:0] mk_word;
		input rfr;
		input lvl;
		begin
			mk_word = {WW{1'b0}};
			mk_word[`ISO_WORD_RFR] = rfr;
			mk_word[`ISO_WORD_LVL] = lvl;
		end
	endfunction

	// Pin synchronisers
	wire [`ISO_PIN_N-1:0] pins_s;

	iso_sync #(
		.W(`ISO_PIN_N),
		.RST_VAL(`ISO_PIN_RST)
	) u_sync (
		.clk_in(ref_clk_in),
		.nrst_in(nrst_in),
		.en_in(clk_en_in),
		.d_in({side2_power_ok_in, side1_power_ok_in, refresh_ctl_side2_n_in,
			refresh_ctl_side1_n_in, channel_a_input_in}),
		.q_out(pins_s)
	);

	wire data_s = pins_s[`ISO_PIN_DATA];
	wire pwr1_s = pins_s[`ISO_PIN_PWR1];
	wire pwr2_s = pins_s[`ISO_PIN_PWR2];
	// Both controls low enables refresh and watchdog
	wire refresh_en = !pins_s[`ISO_PIN_CTL1] && !pins_s[`ISO_PIN_CTL2];

	// Free-running time base
	reg [CW-1:0] tick_cnt_q;
	reg tick_q;

	always @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			tick_cnt_q <= {CW{1'b0}};
			tick_q <= 1'b0;
		end else if (clk_en_in) begin
			if (reached(tick_cnt_q, TICK_LAST)) begin
				tick_cnt_q <= {CW{1'b0}};
				tick_q <= 1'b1;
			end else begin
				tick_cnt_q <= tick_cnt_q + CNT_ONE;
				tick_q <= 1'b0;
			end
		end
	end

	// Barrier FIFO signals
	wire f_in_ready;
	wire f_out_valid;
	wire [WW-1:0] f_out_data;

	// Output side power-up edge
	reg pwr2_prev_q;
	wire pwr2_rise = pwr2_s && !pwr2_prev_q;

	// Input side encoder
	reg prev_q;
	reg [CW-1:0] idle_q;
	reg pend_q;
	reg [WW-1:0] pend_word_q;

	wire in_edge = pwr1_s && (data_s != prev_q);
	wire push = pend_q && f_in_ready;
	wire refresh_due = pwr1_s && refresh_en && tick_q && reached(idle_q, RFR_LAST)
		&& !pend_q && !in_edge;

	always @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			prev_q <= 1'b0;
			idle_q <= {CW{1'b0}};
			pend_q <= 1'b0;
			pend_word_q <= {WW{1'b0}};
		end else if (clk_en_in) begin
			prev_q <= data_s;
			if (!pwr1_s) begin
				// Dead input side sends nothing
				idle_q <= {CW{1'b0}};
				pend_q <= 1'b0;
			end else begin
				if (in_edge || refresh_due) begin
					idle_q <= {CW{1'b0}};
				end else if (tick_q) begin
					idle_q <= step(idle_q);
				end
				if (in_edge) begin
					// Newest edge wins over a stalled one
					pend_q <= 1'b1;
					pend_word_q <= mk_word(1'b0, data_s);
				end else if (pwr2_rise) begin
					pend_q <= 1'b0;
				end else if (refresh_due) begin
					pend_q <= 1'b1;
					pend_word_q <= mk_word(1'b1, data_s);
				end else if (push) begin
					pend_q <= 1'b0;
				end
			end
		end
	end

	iso_fifo #(
		.W(WW),
		.DEPTH(`ISO_FIFO_DEPTH),
		.AW(`ISO_FIFO_AW)
	) u_fifo (
		.clk_in(ref_clk_in),
		.nrst_in(nrst_in),
		.en_in(clk_en_in),
		.flush_in(pwr2_rise),
		.in_valid_in(pend_q && !pwr2_rise),
		.in_data_in(pend_word_q),
		.in_ready_out(f_in_ready),
		.out_valid_out(f_out_valid),
		.out_data_out(f_out_data),
		.out_ready_in(pwr2_s && !pwr2_rise)
	);

	// Output side decoder and watchdog
	reg dec_q;
	reg [CW-1:0] wd_q;
	reg trip_q;
	// Stale word in the read stage must not cross at power-up
	wire pop = f_out_valid && pwr2_s && !pwr2_rise;

	always @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			pwr2_prev_q <= 1'b0;
			dec_q <= DEF_LVL;
			wd_q <= {CW{1'b0}};
			trip_q <= 1'b0;
		end else if (clk_en_in) begin
			pwr2_prev_q <= pwr2_s;
			if (!pwr2_s) begin
				// Unpowered output keeps its last level
				wd_q <= {CW{1'b0}};
				trip_q <= 1'b0;
			end else if (pop) begin
				dec_q <= f_out_data[`ISO_WORD_LVL];
				wd_q <= {CW{1'b0}};
				trip_q <= 1'b0;
			end else if (!refresh_en) begin
				wd_q <= {CW{1'b0}};
			end else if (tick_q) begin
				if (reached(wd_q, WDOG_LIM)) begin
					dec_q <= DEF_LVL;
					trip_q <= 1'b1;
				end else begin
					wd_q <= step(wd_q);
				end
			end
		end
	end

	// Registered outputs
	reg out_q;
	reg oe_n_q;
	reg trip_out_q;
	reg rfr_q;
	reg full_q;

	always @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			out_q <= DEF_LVL;
			oe_n_q <= 1'b1;
			trip_out_q <= 1'b0;
			rfr_q <= 1'b0;
			full_q <= 1'b0;
		end else if (clk_en_in) begin
			out_q <= dec_q;
			oe_n_q <= !pwr2_s;
			trip_out_q <= trip_q;
			rfr_q <= refresh_en;
			full_q <= !f_in_ready;
		end
	end

	assign channel_a_output_out = out_q;
	assign channel_a_output_oe_n_out = oe_n_q;
	assign watchdog_tripped_out = trip_out_q;
	assign refresh_active_out = rfr_q;
	assign barrier_full_out = full_q;
endmodule

// >>> sim/iso_host.sv
// Controlling logic on both sides of the channel
`timescale 1ns/1ns
module iso_host (
	// Pins toward the channel
	output reg din_out = 1'b0,
	output reg ctl1_n_out = 1'b1,
	output reg ctl2_n_out = 1'b1
);
	task drive(input v);
		din_out <= v;
	endtask
	task mode(input rfr);
		begin
			ctl1_n_out <= !rfr;
			ctl2_n_out <= !rfr;
		end
	endtask
endmodule

// >>> sim/iso_top_assertions.sv
// Port checks for the isolator channel
`timescale 1ns/1ns
module iso_chk #(
	parameter DEFAULT_HIGH = 1
) (
	// Pins
	input wire ref_clk_in,
	input wire nrst_in,
	input wire channel_a_input_in,
	input wire refresh_ctl_side1_n_in,
	input wire refresh_ctl_side2_n_in,
	input wire side1_power_ok_in,
	input wire side2_power_ok_in,
	// Outputs
	input wire channel_a_output_out,
	input wire channel_a_output_oe_n_out,
	input wire watchdog_tripped_out,
	input wire refresh_active_out
);
	wire din = channel_a_input_in;
	wire dout = channel_a_output_out;
	wire trip = watchdog_tripped_out;
	wire up = side1_power_ok_in & ~channel_a_output_oe_n_out;
	wire lp = refresh_ctl_side1_n_in & refresh_ctl_side2_n_in;
	wire on = ~(refresh_ctl_side1_n_in | refresh_ctl_side2_n_in);
	reg [3:0] qc_q;
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!nrst_in);
	// Static-input cycles in low-power mode
	always @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in)
			qc_q <= 4'h0;
		else if (!lp || $changed(din))
			qc_q <= 4'h0;
		else if (qc_q != 4'hF)
			qc_q <= qc_q + 4'h1;
	end
	a_rise_sets: assert property (
		(up && $rose(din)) ##1 $stable(din) [*8] |=> ##1 dout) else $error("rise lost");
	a_fall_clears: assert property (
		(up && $fell(din)) ##1 $stable(din) [*8] |=> ##1 !dout) else $error("fall lost");
	a_quiet_hold: assert property (
		qc_q == 4'hF |-> $stable(dout)) else $error("output moved");
	a_refresh_on: assert property (
		on [*4] |-> refresh_active_out) else $error("refresh off");
	a_trip_mode: assert property (
		$rose(trip) |-> refresh_active_out || $past(refresh_active_out))
		else $error("trip in low power");
	a_trip_default: assert property (
		$rose(trip) |-> dout == (DEFAULT_HIGH != 0)) else $error("trip level");
	a_trip_cause: assert property (
		$rose(trip) |-> !$past(side1_power_ok_in, 8)) else $error("early trip");
	a_oe_drive: assert property (
		$rose(side2_power_ok_in) |-> ##[1:5] !channel_a_output_oe_n_out)
		else $error("output not driven");
endmodule

bind iso_top iso_chk #(.DEFAULT_HIGH(DEFAULT_HIGH)) chk_u (.*);

// >>> sim/tb_iso_top.sv
// Self-checking bench for one isolator channel
`timescale 1ns/1ns
module tb_iso_top;
	reg clk = 1'b0, nrst = 1'b0, eo = 1'b0, prev = 1'b0, p1 = 1'b1, p2 = 1'b0, en = 1'b1;
	reg [31:0] r;
	reg exp_q[$];
	integer fails = 0, num_checks = 0, seed = 32'hAC7FC3B1, i;
	wire din, c1, c2, dout, oe_n, trip, ract, full;
	always #10 clk = ~clk;
	iso_host host_u (.din_out(din), .ctl1_n_out(c1), .ctl2_n_out(c2));
	iso_top #(.DEFAULT_HIGH(0), .TICK_CYC(2), .REFRESH_TICKS(4), .WDOG_TICKS(6)) dut_u (
		.ref_clk_in(clk), .nrst_in(nrst), .clk_en_in(en), .channel_a_input_in(din),
		.refresh_ctl_side1_n_in(c1), .side1_power_ok_in(p1), .refresh_ctl_side2_n_in(c2),
		.side2_power_ok_in(p2), .channel_a_output_out(dout),
		.channel_a_output_oe_n_out(oe_n), .watchdog_tripped_out(trip),
		.refresh_active_out(ract), .barrier_full_out(full));
	task chk(input seen, input expd);
		begin
			num_checks = num_checks + 1;
			if (seen !== expd) begin
				fails = fails + 1;
				$display("mismatch at %0t: %h vs %h", $time, seen, expd);
			end
		end
	endtask
	task w(input integer n);
		repeat (n) @(negedge clk);
	endtask
	task setl(input v);
		begin
			if (v !== eo)
				exp_q.push_back(v);
			eo = v;
			host_u.drive(v);
		end
	endtask
	task final_report;
		begin
			$display("checks %0d fails %0d", num_checks, fails);
			if (fails == 0 && num_checks > 0)
				$display("All tests passed");
			else
				$display("Some tests failed");
			$finish;
		end
	endtask
	// Each output change takes the oldest expected level
	always @(negedge clk) begin
		if (nrst && dout !== prev)
			chk(dout, exp_q.size() > 0 ? exp_q.pop_front() : prev);
		prev = dout;
	end
	initial begin
		#200000;
		fails = fails + 1;
		final_report;
	end
	initial begin
		repeat (12) @(negedge clk);
		nrst = 1'b1;
		// Edges pile up while the output side is down
		for (i = 0; i < 40; i = i + 1) begin
			host_u.drive(i[0]);
			w(4);
		end
		chk(full, 1'b1);
		p2 <= 1'b1;
		w(30);
		chk(dout, 1'b0);
		chk(full, 1'b0);
		chk(oe_n, 1'b0);
		setl(1'b0);
		w(16);
		setl(1'b1);
		w(16);
		$display("test 1 done");
		for (i = 0; i < 20; i = i + 1) begin
			r = $random(seed);
			setl(r[0]);
			w(12 + r[7:4]);
		end
		$display("test 2 done");
		setl(1'b1);
		host_u.mode(1'b1);
		w(100);
		chk(ract, 1'b1);
		chk(trip, 1'b0);
		exp_q.push_back(1'b0);
		// Frozen enable stops the time base and the watchdog
		en <= 1'b0;
		p1 <= 1'b0;
		w(60);
		chk(trip, 1'b0);
		chk(dout, 1'b1);
		en <= 1'b1;
		w(60);
		chk(trip, 1'b1);
		chk(dout, 1'b0);
		exp_q.push_back(1'b1);
		p1 <= 1'b1;
		w(40);
		chk(trip, 1'b0);
		$display("test 3 done");
		host_u.mode(1'b0);
		w(10);
		p1 <= 1'b0;
		w(60);
		chk(trip, 1'b0);
		chk(dout, 1'b1);
		chk(exp_q.size() == 0, 1'b1);
		$display("test 4 done");
		final_report;
	end
endmodule
